/* logic/dmem_pkg.sv */
// Package with data memory map, status field layout and core command types.
package dmem_pkg;

   // ----------------------------------------------------------------------
   // Address map
   // ----------------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam logic [7:0] IND_PORT_ADDR = 8'h00;
   localparam logic [7:0] MEM_PTR_ADDR = 8'h01;
   localparam logic [7:0] ACC_ADDR = 8'h05;
   localparam logic [7:0] PC_LOW_ADDR = 8'h06;
   localparam logic [7:0] TBLP_ADDR = 8'h07;
   localparam logic [7:0] TBL_HIGH_ADDR = 8'h08;
   localparam logic [7:0] STATUS_ADDR = 8'h0A;
   localparam logic [7:0] IRQ_CTRL_ADDR = 8'h0B;
   localparam logic [7:0] TBL_PAGE_ADDR = 8'h1F;
   localparam logic [7:0] GP_BASE = 8'h20;
   localparam int GP_DEPTH = 96;

   // ----------------------------------------------------------------------
   // Status register bit positions
   // ----------------------------------------------------------------------
   localparam int ST_C = 0;
   localparam int ST_HALF = 1;
   localparam int ST_Z = 2;
   localparam int ST_WRAP = 3;
   localparam int ST_HALT = 4;
   localparam int ST_WDOG = 5;
   localparam logic [7:0] STATUS_ARITH_MASK = 8'h0F;

   // Interrupt control bit positions.
   localparam int IC_GIE = 0;
   localparam int IC_TMR = 1;
   localparam logic [7:0] IRQ_CTRL_MASK = 8'h03;

   // Reset value and forced last page bits.
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [2:0] PAGE_LAST = 3'b111;

   // ----------------------------------------------------------------------
   // Core command carriers
   // ----------------------------------------------------------------------
   typedef enum logic [3:0] {
      ALU_NONE = 4'b0000,
      ALU_ADD = 4'b0001,
      ALU_SUB = 4'b0010,
      ALU_AND = 4'b0011,
      ALU_OR = 4'b0100,
      ALU_XOR = 4'b0101,
      ALU_RLC = 4'b0110,
      ALU_RRC = 4'b0111,
      ALU_PASS = 4'b1000
   } alu_op_t;

   typedef struct packed {
      logic rd;
      logic wr;
      logic bit_set;
      logic bit_clr;
      logic [2:0] bit_sel;
      logic [7:0] addr;
      logic [7:0] wdata;
   } mem_req_t;

   typedef struct packed {
      alu_op_t op;
      logic [7:0] a;
      logic [7:0] b;
      logic to_acc;
   } alu_req_t;

   typedef struct packed {
      logic tbl_rd;
      logic last_page;
      logic [7:0] dest;
   } tbl_req_t;

endpackage : dmem_pkg

/* logic/gp_ram.sv */
// General purpose byte RAM with registered read data.
`timescale 1ns/1ps
module gp_ram #(
   parameter int DEPTH = 96,
   parameter int AW = 7
) (
   input wire logic i_clk,           // System clock.
   input wire logic i_we,            // Write enable.
   input wire logic [AW-1:0] i_addr, // Word address.
   input wire logic [7:0] i_wdata,   // Write data.
   output logic [7:0] o_rdata        // Registered read data.
);
   logic [7:0] mem [DEPTH];

   // ----------------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------------
   // Write and registered read share one port; no reset on storage contents.
   always_ff @(posedge i_clk) begin
      if (i_we) begin
         mem[i_addr] <= i_wdata;
      end
      o_rdata <= mem[i_addr];
   end
endmodule : gp_ram

/* logic/data_memory_sfr_file.sv */
// Data memory and special function register file of the 8-bit core.
//
// Functional notes
// - Byte RAM from address zero, special area then general area contiguously.
// - Unused special area locations below general memory read as zero.
// - Indirect port has no storage; accesses go to the pointed location.
// - Pointer at indirect port itself: read gives zero, write ignored.
// - Memory pointer is a real register, readable, writable and modifiable.
// - Single bit set and clear work except on protected bits.
// - Writing program counter low byte jumps within page, adds dummy cycle.
// - No register to register moves; accumulator holds ALU results when to_acc is set.
// - Table read puts high part in latch, low byte to destination if in general memory.
// - Current page table read uses page pointer if enabled, else counter.
// - Table bits 10..8 from page pointer or counter; last page forces ones.
// - Status writes change only arithmetic flags, not watchdog or halt flags.
// - Watchdog flag cleared by reset, watchdog clear or halt; set on time-out.
// - Halt flag cleared by reset or watchdog clear; set by halt.
// - Carry set on add carry or subtract no-borrow; rotates also update it.
// - Half carry set on low nibble carry or no nibble borrow.
// - Zero flag set on zero arithmetic or logic result.
// - Overflow set when carry into top bit differs from carry out.
// - Status is not saved on interrupt entry or call.
// - Interrupt control holds timer enable and a global enable.
// - Global enable cleared on interrupt entry, set by interrupt return.
// - Read-only registers ignore writes; general locations fully read/write.
`timescale 1ns/1ps
module data_memory_sfr_file #(
   parameter int PC_W = 11,   // Program counter width.
   parameter int ROM_W = 15   // Program memory word width.
) (
   input wire logic I_CLK_SYS,                   // System clock, 25 MHz.
   input wire logic I_RESET_N,                   // Power-up reset, active low.
   input wire dmem_pkg::mem_req_t I_MEM_REQ,     // Data memory access from core.
   input wire dmem_pkg::alu_req_t I_ALU_REQ,     // ALU operation from core.
   input wire dmem_pkg::tbl_req_t I_TBL_REQ,     // Table read request.
   input wire logic [PC_W-1:0] I_PC,             // Current program counter.
   input wire logic [ROM_W-1:0] I_ROM_DATA,      // Program memory word for table read.
   input wire logic I_PAGE_PTR_EN,               // Page pointer option enabled.
   input wire logic I_WDT_TIMEOUT,               // Watchdog time-out pulse.
   input wire logic I_WDT_CLEAR,                 // Watchdog clear instruction pulse.
   input wire logic I_HALT,                      // Halt instruction pulse.
   input wire logic I_IRQ_ENTER,                 // Interrupt entry pulse.
   input wire logic I_IRQ_RETURN,                // Interrupt return instruction pulse.
   output logic [7:0] O_RDATA,                   // Read data, valid one cycle after read.
   output logic [7:0] O_ACC,                     // Working accumulator.
   output logic [7:0] O_STATUS,                  // Status flags.
   output logic [PC_W-1:0] O_TBL_ADDR,           // Table read address to program memory.
   output logic O_PC_LOAD,                       // Pulse: load low program counter byte.
   output logic [7:0] O_PC_LOW,                  // New low byte for the jump.
   output logic O_DUMMY_CYCLE,                   // Pulse: insert dummy cycle.
   output logic O_GLOBAL_IRQ_EN,                 // Global interrupt enable.
   output logic O_TMR_IRQ_EN                     // Timer interrupt enable gated by global.
);
   import dmem_pkg::*;

   // ----------------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------------
   logic [7:0] mem_pointer_reg;
   logic [7:0] acc_reg, tblp_reg, table_page_pointer_reg, table_high_latch_reg;
   logic [7:0] status_reg, irq_control_reg, sfr_rdata_reg, tbl_dest_reg;
   logic sel_ram_reg, tbl_pend_reg;

   // ----------------------------------------------------------------------
   // Address resolution
   // ----------------------------------------------------------------------
   logic [7:0] eff_addr, cur_val, bit_mask, wr_val, ram_rdata;
   logic [6:0] gp_index;
   logic ind_self, is_gp, wr_any, wr_eff, tbl_to_gp;

   // Accesses to the indirect port are redirected through the pointer.
   always_comb begin
      eff_addr = (I_MEM_REQ.addr == IND_PORT_ADDR) ? mem_pointer_reg :
                 I_MEM_REQ.addr;
      ind_self = (I_MEM_REQ.addr == IND_PORT_ADDR) &&
                 (mem_pointer_reg == IND_PORT_ADDR);
      is_gp = (eff_addr >= GP_BASE) && (eff_addr < GP_BASE + 8'(GP_DEPTH));
      gp_index = 7'(eff_addr - GP_BASE);
      tbl_to_gp = (tbl_dest_reg >= GP_BASE) && (tbl_dest_reg < GP_BASE + 8'(GP_DEPTH));
   end

   // ----------------------------------------------------------------------
   // Special register read mux
   // ----------------------------------------------------------------------
   // Unused special locations and the port itself read as zero.
   always_comb begin
      case (eff_addr)
         MEM_PTR_ADDR: cur_val = mem_pointer_reg;
         ACC_ADDR: cur_val = acc_reg;
         PC_LOW_ADDR: cur_val = I_PC[7:0];
         TBLP_ADDR: cur_val = tblp_reg;
         TBL_HIGH_ADDR: cur_val = table_high_latch_reg;
         STATUS_ADDR: cur_val = status_reg;
         IRQ_CTRL_ADDR: cur_val = irq_control_reg;
         TBL_PAGE_ADDR: cur_val = table_page_pointer_reg;
         default: cur_val = RST_BYTE;
      endcase
   end

   // ----------------------------------------------------------------------
   // Write value, including single bit set and clear
   // ----------------------------------------------------------------------
   // Bit operations are read-modify-write; the RAM location needs its old
   // value, so bit ops on general memory use the value the core supplies
   // in wdata as the byte to modify. This keeps the RAM single ported.
   always_comb begin
      bit_mask = 8'h01 << I_MEM_REQ.bit_sel;
      wr_any = I_MEM_REQ.wr | I_MEM_REQ.bit_set | I_MEM_REQ.bit_clr;
      if (I_MEM_REQ.bit_set) begin
         wr_val = (is_gp ? I_MEM_REQ.wdata : cur_val) | bit_mask;
      end else if (I_MEM_REQ.bit_clr) begin
         wr_val = (is_gp ? I_MEM_REQ.wdata : cur_val) & ~bit_mask;
      end else begin
         wr_val = I_MEM_REQ.wdata;
      end
      wr_eff = wr_any && !ind_self;
   end

   // ----------------------------------------------------------------------
   // General purpose RAM
   // ----------------------------------------------------------------------
   gp_ram #(
      .DEPTH(GP_DEPTH),
      .AW(7)
   ) u_gp_ram (
      .i_clk(I_CLK_SYS),
      .i_we(tbl_pend_reg ? tbl_to_gp : (wr_eff && is_gp)),
      .i_addr(tbl_pend_reg ? 7'(tbl_dest_reg - GP_BASE) : gp_index),
      .i_wdata(tbl_pend_reg ? I_ROM_DATA[7:0] : wr_val),
      .o_rdata(ram_rdata)
   );

   // ----------------------------------------------------------------------
   // Read data path
   // ----------------------------------------------------------------------
   // Read data appear one cycle after the request, matching the RAM latency.
   always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         sfr_rdata_reg <= RST_BYTE;
         sel_ram_reg <= 1'b0;
      end else begin
         sfr_rdata_reg <= ind_self ? RST_BYTE : cur_val;
         sel_ram_reg <= is_gp && !ind_self;
      end
   end

   always_comb begin
      O_RDATA = sel_ram_reg ? ram_rdata : sfr_rdata_reg;
   end

   // ----------------------------------------------------------------------
   // Memory pointer and table pointers
   // ----------------------------------------------------------------------
   always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         mem_pointer_reg <= RST_BYTE;
         tblp_reg <= RST_BYTE;
         table_page_pointer_reg <= RST_BYTE;
      end else if (wr_eff) begin
         if (eff_addr == MEM_PTR_ADDR) begin
            mem_pointer_reg <= wr_val;
         end
         if (eff_addr == TBLP_ADDR) begin
            tblp_reg <= wr_val;
         end
         if (eff_addr == TBL_PAGE_ADDR) begin
            table_page_pointer_reg <= wr_val;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Accumulator and ALU
   // ----------------------------------------------------------------------
   logic [8:0] sum9;
   logic [4:0] nib5;
   logic [7:0] low7, alu_res;
   logic alu_c, alu_ac, alu_ov, alu_arith, alu_logic, alu_rot;

   // Subtraction is done as a + ~b + 1, so the carry out is the no-borrow.
   always_comb begin
      sum9 = 9'h000;
      nib5 = 5'h00;
      low7 = 8'h00;
      alu_res = I_ALU_REQ.a;
      alu_c = status_reg[ST_C];
      alu_ac = status_reg[ST_HALF];
      alu_ov = status_reg[ST_WRAP];
      alu_arith = 1'b0;
      alu_logic = I_ALU_REQ.op inside {ALU_AND, ALU_OR, ALU_XOR};
      alu_rot = 1'b0;
      case (I_ALU_REQ.op)
         ALU_ADD, ALU_SUB: begin
            alu_arith = 1'b1;
            if (I_ALU_REQ.op == ALU_ADD) begin
               sum9 = {1'b0, I_ALU_REQ.a} + {1'b0, I_ALU_REQ.b};
               nib5 = {1'b0, I_ALU_REQ.a[3:0]} + {1'b0, I_ALU_REQ.b[3:0]};
               low7 = {1'b0, I_ALU_REQ.a[6:0]} + {1'b0, I_ALU_REQ.b[6:0]};
            end else begin
               sum9 = {1'b0, I_ALU_REQ.a} + {1'b0, ~I_ALU_REQ.b} + 9'h001;
               nib5 = {1'b0, I_ALU_REQ.a[3:0]} + {1'b0, ~I_ALU_REQ.b[3:0]} + 5'h01;
               low7 = {1'b0, I_ALU_REQ.a[6:0]} + {1'b0, ~I_ALU_REQ.b[6:0]} + 8'h01;
            end
            alu_res = sum9[7:0];
            alu_c = sum9[8];
            alu_ac = nib5[4];
            alu_ov = low7[7] ^ sum9[8];
         end
         ALU_AND: alu_res = I_ALU_REQ.a & I_ALU_REQ.b;
         ALU_OR: alu_res = I_ALU_REQ.a | I_ALU_REQ.b;
         ALU_XOR: alu_res = I_ALU_REQ.a ^ I_ALU_REQ.b;
         ALU_RLC: begin
            alu_rot = 1'b1;
            alu_res = {I_ALU_REQ.a[6:0], status_reg[ST_C]};
            alu_c = I_ALU_REQ.a[7];
         end
         ALU_RRC: begin
            alu_rot = 1'b1;
            alu_res = {status_reg[ST_C], I_ALU_REQ.a[7:1]};
            alu_c = I_ALU_REQ.a[0];
         end
         ALU_PASS: alu_res = I_ALU_REQ.a;
         default: alu_res = I_ALU_REQ.a;
      endcase
   end

   // ALU results with to_acc set land in the accumulator; moves go through it too.
   always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         acc_reg <= RST_BYTE;
      end else if (I_ALU_REQ.op != ALU_NONE && I_ALU_REQ.to_acc) begin
         acc_reg <= alu_res;
      end else if (wr_eff && eff_addr == ACC_ADDR) begin
         acc_reg <= wr_val;
      end
   end

   // ----------------------------------------------------------------------
   // Status flags
   // ----------------------------------------------------------------------
   // Nothing pushes status on interrupt entry or call; software saves it.
   always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         status_reg <= RST_BYTE;
      end else begin
         if (wr_eff && eff_addr == STATUS_ADDR) begin
            status_reg[3:0] <= wr_val[3:0];
         end
         if (alu_arith) begin
            status_reg[ST_C] <= alu_c;
            status_reg[ST_HALF] <= alu_ac;
            status_reg[ST_WRAP] <= alu_ov;
         end
         if (alu_rot) begin
            status_reg[ST_C] <= alu_c;
         end
         if (alu_arith || alu_logic) begin
            status_reg[ST_Z] <= (alu_res == 8'h00);
         end
         // Time-out is applied last so it wins over a same-cycle clear.
         if (I_WDT_CLEAR || I_HALT) begin
            status_reg[ST_WDOG] <= 1'b0;
         end
         if (I_WDT_TIMEOUT) begin
            status_reg[ST_WDOG] <= 1'b1;
         end
         if (I_WDT_CLEAR) begin
            status_reg[ST_HALT] <= 1'b0;
         end
         if (I_HALT) begin
            status_reg[ST_HALT] <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Interrupt control
   // ----------------------------------------------------------------------
   always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         irq_control_reg <= RST_BYTE;
      end else begin
         if (wr_eff && eff_addr == IRQ_CTRL_ADDR) begin
            irq_control_reg <= wr_val & IRQ_CTRL_MASK;
         end
         if (I_IRQ_RETURN) begin
            irq_control_reg[IC_GIE] <= 1'b1;
         end
         if (I_IRQ_ENTER) begin
            irq_control_reg[IC_GIE] <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Program counter low byte
   // ----------------------------------------------------------------------
   // The jump stays within the page because only eight bits are loaded.
   always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         O_PC_LOAD <= 1'b0;
         O_PC_LOW <= RST_BYTE;
         O_DUMMY_CYCLE <= 1'b0;
      end else begin
         O_PC_LOAD <= wr_eff && eff_addr == PC_LOW_ADDR;
         O_DUMMY_CYCLE <= wr_eff && eff_addr == PC_LOW_ADDR;
         if (wr_eff && eff_addr == PC_LOW_ADDR) begin
            O_PC_LOW <= wr_val;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Table read
   // ----------------------------------------------------------------------
   // Cycle one presents the address; cycle two captures the word.
   always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         O_TBL_ADDR <= '0;
         tbl_pend_reg <= 1'b0;
         tbl_dest_reg <= RST_BYTE;
         table_high_latch_reg <= RST_BYTE;
      end else begin
         tbl_pend_reg <= I_TBL_REQ.tbl_rd;
         if (I_TBL_REQ.tbl_rd) begin
            tbl_dest_reg <= I_TBL_REQ.dest;
            if (I_TBL_REQ.last_page) begin
               O_TBL_ADDR <= {PAGE_LAST, tblp_reg};
            end else if (I_PAGE_PTR_EN) begin
               O_TBL_ADDR <= {table_page_pointer_reg[2:0], tblp_reg};
            end else begin
               O_TBL_ADDR <= {I_PC[10:8], tblp_reg};
            end
         end
         if (tbl_pend_reg) begin
            table_high_latch_reg <= 8'(I_ROM_DATA[ROM_W-1:8]);
         end
      end
   end

   // ----------------------------------------------------------------------
   // Output registers
   // ----------------------------------------------------------------------
   always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         O_ACC <= RST_BYTE;
         O_STATUS <= RST_BYTE;
         O_GLOBAL_IRQ_EN <= 1'b0;
         O_TMR_IRQ_EN <= 1'b0;
      end else begin
         O_ACC <= acc_reg;
         O_STATUS <= status_reg;
         O_GLOBAL_IRQ_EN <= irq_control_reg[IC_GIE];
         O_TMR_IRQ_EN <= irq_control_reg[IC_GIE] & irq_control_reg[IC_TMR];
      end
   end

endmodule : data_memory_sfr_file

/* verif/prog_rom_model.sv */
// Program memory stand-in that answers table reads of the block.
`timescale 1ns/1ps
module prog_rom_model (
   input wire logic [10:0] i_addr, // Table address.
   output logic [14:0] o_data      // Program word.
);
   // Every address bit shapes the word, so a wrong page or pointer bit shows up.
   assign o_data = {i_addr[10:4], i_addr[7:0] ^ i_addr[10:3]};
endmodule : prog_rom_model

/* verif/dmem_asserts.sv */
// Port timing checks for the data memory file.
`timescale 1ns/1ps
module dmem_asserts #(
   parameter int PC_W = 11 // Counter width.
) (
   input wire logic I_CLK_SYS, // Clock.
   input wire logic I_RESET_N, // Reset.
   input wire dmem_pkg::mem_req_t I_MEM_REQ, // Memory request.
   input wire dmem_pkg::alu_req_t I_ALU_REQ, // ALU request.
   input wire dmem_pkg::tbl_req_t I_TBL_REQ, // Table request.
   input wire logic [PC_W-1:0] I_PC, // Counter.
   input wire logic I_PAGE_PTR_EN, // Page option.
   input wire logic I_WDT_TIMEOUT, // Time-out.
   input wire logic I_HALT, // Halt.
   input wire logic I_IRQ_ENTER, // Entry.
   input wire logic [7:0] O_RDATA, // Read data.
   input wire logic [7:0] O_STATUS, // Flags.
   input wire logic [PC_W-1:0] O_TBL_ADDR, // Table address.
   input wire logic O_PC_LOAD, // Jump.
   input wire logic [7:0] O_PC_LOW, // Jump byte.
   input wire logic O_DUMMY_CYCLE, // Spare cycle.
   input wire logic O_GLOBAL_IRQ_EN // Global enable.
);
   import dmem_pkg::*;
   default clocking cb @(posedge I_CLK_SYS);
   endclocking
   default disable iff (!I_RESET_N);
   // Jumps, reads and table addresses answer one edge after the request.
   a_jump_pulse: assert property (I_MEM_REQ.wr && I_MEM_REQ.addr == PC_LOW_ADDR |=>
      O_PC_LOAD && O_DUMMY_CYCLE && O_PC_LOW == $past(I_MEM_REQ.wdata))
      else $error("jump pulse wrong");
   a_unused_reads_zero: assert property (
      I_MEM_REQ.rd && I_MEM_REQ.addr inside {[8'h0C:8'h1E]} |=> O_RDATA == 8'h00)
      else $error("unused place not zero");
   a_last_page_ones: assert property (I_TBL_REQ.tbl_rd && I_TBL_REQ.last_page |=>
      O_TBL_ADDR[10:8] == PAGE_LAST) else $error("last page bits wrong");
   a_page_from_pc: assert property (
      I_TBL_REQ.tbl_rd && !I_TBL_REQ.last_page && !I_PAGE_PTR_EN |=>
      O_TBL_ADDR[10:8] == $past(I_PC[10:8])) else $error("page bits wrong");
   // Flags show two edges after their cause, since the port is a copy.
   a_timeout_sets_flag: assert property ($rose(O_STATUS[ST_WDOG]) |->
      $past(I_WDT_TIMEOUT, 2)) else $error("time-out flag rose alone");
   a_halt_sets_flag: assert property ($rose(O_STATUS[ST_HALT]) |->
      $past(I_HALT, 2)) else $error("halt flag rose alone");
   a_zero_flag: assert property (I_ALU_REQ.op == ALU_AND |-> ##2
      O_STATUS[ST_Z] == (($past(I_ALU_REQ.a, 2) & $past(I_ALU_REQ.b, 2)) == 8'h00))
      else $error("zero flag wrong");
   a_irq_entry_masks: assert property (I_IRQ_ENTER |=> ##[0:1] !O_GLOBAL_IRQ_EN)
      else $error("global enable kept");
endmodule : dmem_asserts
bind data_memory_sfr_file dmem_asserts #(.PC_W(PC_W)) u_chk (.I_CLK_SYS(I_CLK_SYS),
   .I_RESET_N(I_RESET_N), .I_MEM_REQ(I_MEM_REQ), .I_ALU_REQ(I_ALU_REQ),
   .I_TBL_REQ(I_TBL_REQ), .I_PC(I_PC), .I_PAGE_PTR_EN(I_PAGE_PTR_EN),
   .I_WDT_TIMEOUT(I_WDT_TIMEOUT), .I_HALT(I_HALT), .I_IRQ_ENTER(I_IRQ_ENTER),
   .O_RDATA(O_RDATA), .O_STATUS(O_STATUS), .O_TBL_ADDR(O_TBL_ADDR), .O_PC_LOAD(O_PC_LOAD),
   .O_PC_LOW(O_PC_LOW), .O_DUMMY_CYCLE(O_DUMMY_CYCLE), .O_GLOBAL_IRQ_EN(O_GLOBAL_IRQ_EN));

/* verif/tb_data_memory_sfr_file.sv */
// Self-checking testbench for the data memory file.
`timescale 1ns/1ps
module tb_data_memory_sfr_file;
   import dmem_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   mem_req_t mreq = '0;
   alu_req_t areq = '0;
   tbl_req_t treq = '0;
   logic [4:0] ev = '0; // Time-out, clear, halt, entry, return.
   logic en = 1'b0;
   logic [10:0] taddr;
   logic [14:0] rom, word;
   logic [7:0] rdata, acc, status, seen;
   logic gie, tie;
   int bad_count = 0;
   int checks_done = 0;
   int cyc = 0;
   // Memory steps: {rd wr set clr, address, data, expected read}.
   logic [27:0] ops [0:19] = '{
      {4'h4, 8'h20, 8'hA5, 8'h00}, {4'h4, 8'h7F, 8'h3C, 8'h00},
      {4'h8, 8'h20, 8'h00, 8'hA5},
      {4'h8, 8'h7F, 8'h00, 8'h3C},
      {4'h8, 8'h0C, 8'h00, 8'h00}, {4'h8, 8'h1E, 8'h00, 8'h00},
      {4'h4, 8'h01, 8'h21, 8'h00}, {4'h4, 8'h00, 8'h5E, 8'h00},
      {4'h8, 8'h21, 8'h00, 8'h5E},
      {4'h2, 8'h01, 8'h07, 8'h00}, {4'h1, 8'h01, 8'h00, 8'h00},
      {4'h8, 8'h01, 8'h00, 8'hA0},
      {4'h4, 8'h01, 8'h00, 8'h00}, {4'h4, 8'h00, 8'h99, 8'h00},
      {4'h8, 8'h00, 8'h00, 8'h00},
      {4'h4, 8'h08, 8'h55, 8'h00}, {4'h8, 8'h08, 8'h00, 8'h00},
      {4'h4, 8'h06, 8'h42, 8'h00}, {4'h4, 8'h0A, 8'hFF, 8'h00},
      {4'h8, 8'h0A, 8'h00, 8'h0F}};
   // ALU steps: {op, a, b, flag mask, flags, accumulator}; carry feeds the rotates.
   logic [35:0] alu_ops [0:8] = '{
      {ALU_SUB, 8'h05, 8'h05, 4'hF, 4'h7, 8'h00},
      {ALU_RLC, 8'h81, 8'h81, 4'h1, 4'h1, 8'h03},
      {ALU_RRC, 8'h01, 8'h01, 4'h1, 4'h1, 8'h80},
      {ALU_ADD, 8'h7F, 8'h01, 4'hF, 4'hA, 8'h80},
      {ALU_ADD, 8'h80, 8'h80, 4'hF, 4'hD, 8'h00},
      {ALU_AND, 8'hF0, 8'h0F, 4'h4, 4'h4, 8'h00},
      {ALU_OR, 8'h12, 8'h00, 4'h4, 4'h0, 8'h12},
      {ALU_XOR, 8'h5A, 8'h5A, 4'h4, 4'h4, 8'h00},
      {ALU_PASS, 8'h3C, 8'h3C, 4'h0, 4'h0, 8'h3C}};
   // Event steps: {pulses, time-out and halt flags, enables}.
   logic [7:0] evs [0:6] = '{{5'h10, 2'b10, 1'b1}, {5'h04, 2'b01, 1'b1},
      {5'h08, 2'b00, 1'b1}, {5'h04, 2'b01, 1'b1}, {5'h10, 2'b11, 1'b1},
      {5'h02, 2'b11, 1'b0}, {5'h01, 2'b11, 1'b1}};
   // Table steps: {last page, page option, expected address}.
   logic [12:0] tbs [0:2] = '{{2'b10, 11'h706}, {2'b01, 11'h506}, {2'b00, 11'h306}};

   data_memory_sfr_file u_dut (.I_CLK_SYS(clk), .I_RESET_N(rst_n), .I_MEM_REQ(mreq),
      .I_ALU_REQ(areq), .I_TBL_REQ(treq), .I_PC(11'h3A0), .I_ROM_DATA(rom),
      .I_PAGE_PTR_EN(en), .I_WDT_TIMEOUT(ev[4]), .I_WDT_CLEAR(ev[3]), .I_HALT(ev[2]),
      .I_IRQ_ENTER(ev[1]), .I_IRQ_RETURN(ev[0]), .O_RDATA(rdata), .O_ACC(acc),
      .O_STATUS(status), .O_TBL_ADDR(taddr), .O_PC_LOAD(), .O_PC_LOW(),
      .O_DUMMY_CYCLE(), .O_GLOBAL_IRQ_EN(gie), .O_TMR_IRQ_EN(tie));
   prog_rom_model u_rom (.i_addr(taddr), .o_data(rom));

   task automatic close_out();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : close_out
   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected %s: expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   // Inputs move just after the rising edge so the design samples them settled.
   task automatic step();
      @(posedge clk);
      #1;
   endtask : step
   task automatic mem(input logic [3:0] k, input logic [7:0] a, input logic [7:0] d);
      mreq = {k, d[2:0], a, d};
      step();
      seen = rdata;
      mreq = '0;
      step();
   endtask : mem

   initial begin
      forever #20 clk = ~clk;
   end
   // A hang is cut short well past the roughly 115 cycles the run needs.
   always @(posedge clk) begin
      cyc++;
      if (cyc == 2000) begin
         bad_count++;
         close_out();
      end
   end
   initial begin
      repeat (10) @(posedge clk);
      #1 rst_n = 1'b1;
      step();
      foreach (ops[i]) begin
         mem(ops[i][27:24], ops[i][23:16], ops[i][15:8]);
         if (ops[i][27])
            chk("rdata", ops[i][7:0], seen);
      end
      foreach (alu_ops[i]) begin
         areq = {alu_ops[i][35:16], 1'b1};
         step();
         areq = '0;
         step();
         chk("acc", alu_ops[i][7:0], acc);
         chk("flags", alu_ops[i][11:8], status[3:0] & alu_ops[i][15:12]);
      end
      mem(4'h4, IRQ_CTRL_ADDR, 8'h03);
      foreach (evs[i]) begin
         ev = evs[i][7:3];
         step();
         ev = '0;
         step();
         chk("halt_wdt", evs[i][2:1], status[5:4]);
         chk("irq_en", {2{evs[i][0]}}, {gie, tie});
      end
      mem(4'h4, STATUS_ADDR, 8'h00);
      mem(4'h8, STATUS_ADDR, 8'h00);
      chk("status", 8'h30, seen);
      mem(4'h4, TBLP_ADDR, 8'h06);
      mem(4'h4, TBL_PAGE_ADDR, 8'h05);
      foreach (tbs[i]) begin
         en = tbs[i][11];
         treq = {1'b1, tbs[i][12], 8'h22};
         step();
         treq = '0;
         chk("tbl_addr", tbs[i][10:0], taddr);
         step();
         step();
         word = {tbs[i][10:4], tbs[i][7:0] ^ tbs[i][10:3]};
         mem(4'h8, TBL_HIGH_ADDR, 8'h00);
         chk("tbl_high", {1'b0, word[14:8]}, seen);
         mem(4'h8, 8'h22, 8'h00);
         chk("tbl_low", word[7:0], seen);
      end
      close_out();
   end
endmodule : tb_data_memory_sfr_file
